/* acc_xfer_regs.svh */
`ifndef ACC_XFER_REGS_SVH
`define ACC_XFER_REGS_SVH

// ==========================================================
// Register byte addresses on the APB side.
`define ADDR_INSTR 12'h000
`define ADDR_ACC 12'h004
`define ADDR_OPB 12'h008
`define ADDR_COL 12'h00c
`define ADDR_ROW 12'h010
`define ADDR_CARRY 12'h014
`define ADDR_MEMDATA 12'h018
`define ADDR_FR3 12'h020
`define ADDR_IRQ1 12'h024
`define ADDR_IRQ2 12'h028
`define ADDR_SIO 12'h02c
`define ADDR_WAKE0 12'h030
`define ADDR_WAKE1 12'h034
`define ADDR_WAKE2 12'h038
`define ADDR_CLK 12'h03c
`define ADDR_TAUX 12'h040
`define ADDR_PSRLD 12'h044
`define ADDR_PSCNT 12'h048
`define ADDR_PU0 12'h04c
`define ADDR_PU1 12'h050
`define ADDR_ADC1 12'h054
`define ADDR_ADC2 12'h058
`define ADDR_ADC3 12'h05c
`define ADDR_TRLD1 12'h060
`define ADDR_TRLD3 12'h064

// ==========================================================
// Instruction encodings.
`define OPC_FR3 10'h22b
`define OPC_IRQ1 10'h217
`define OPC_IRQ2 10'h218
`define OPC_SIO 10'h202
`define OPC_WAKE0 10'h21b
`define OPC_WAKE1 10'h214
`define OPC_WAKE2 10'h215
`define OPC_CLK 10'h296
`define OPC_TAUX 10'h2aa
`define OPC_PS 10'h235
`define OPC_PU0 10'h22d
`define OPC_PU1 10'h22e
`define OPC_ADC1 10'h204
`define OPC_ADC2 10'h205
`define OPC_ADC3 10'h206
`define OPC_TRLD1 10'h23f
`define OPC_TRLD3 10'h23b
`define OPC_STORE_HI 6'h2b

// ==========================================================
// Reset values.
`define RST_NIB 4'h0
`define RST_BYTE 8'h00
`define RST_OPC 10'h000

`endif

/* acc_xfer_pkg.sv */
package acc_xfer_pkg;

	// Decoded operation of one instruction word.
	typedef enum logic [4:0] {
		OP_NONE,
		OP_FR3,
		OP_IRQ1,
		OP_IRQ2,
		OP_SIO,
		OP_WAKE0,
		OP_WAKE1,
		OP_WAKE2,
		OP_STORE,
		OP_CLK,
		OP_TAUX,
		OP_PS,
		OP_PU0,
		OP_PU1,
		OP_ADC1,
		OP_ADC2,
		OP_ADC3,
		OP_TRLD1,
		OP_TRLD3
	} op_t;

endpackage

/* decode_if.sv */
`timescale 1ns/10ps

// Carries an opcode to the decoder and the decoded operation back.
interface decode_if;
	import acc_xfer_pkg::*;
	logic [9:0] opcode;
	op_t op;
	logic [3:0] imm;
	modport core (output opcode, input op, input imm);
	modport dec (input opcode, output op, output imm);
endinterface

/* opcode_decode.sv */
`timescale 1ns/10ps
`include "acc_xfer_regs.svh"

module opcode_decode
(
	decode_if.dec dif
);
	import acc_xfer_pkg::*;

	// ==========================================================
	// Full-width compare of the opcode, store on bits 9:4 only; anything unknown decodes to no operation.
	always_comb
	begin
		dif.imm = dif.opcode[3:0];
		if (dif.opcode[9:4] == `OPC_STORE_HI) // [RULE_06]
			dif.op = OP_STORE;
		else
		begin
			case (dif.opcode) // [RULE_15]
				`OPC_FR3: dif.op = OP_FR3; // [RULE_02]
				`OPC_IRQ1: dif.op = OP_IRQ1; // [RULE_03]
				`OPC_IRQ2: dif.op = OP_IRQ2; // [RULE_03]
				`OPC_SIO: dif.op = OP_SIO; // [RULE_04]
				`OPC_WAKE0: dif.op = OP_WAKE0; // [RULE_05]
				`OPC_WAKE1: dif.op = OP_WAKE1; // [RULE_05]
				`OPC_WAKE2: dif.op = OP_WAKE2; // [RULE_05]
				`OPC_CLK: dif.op = OP_CLK; // [RULE_07]
				`OPC_TAUX: dif.op = OP_TAUX; // [RULE_08]
				`OPC_PS: dif.op = OP_PS; // [RULE_09]
				`OPC_PU0: dif.op = OP_PU0; // [RULE_10]
				`OPC_PU1: dif.op = OP_PU1; // [RULE_10]
				`OPC_ADC1: dif.op = OP_ADC1; // [RULE_11]
				`OPC_ADC2: dif.op = OP_ADC2; // [RULE_11]
				`OPC_ADC3: dif.op = OP_ADC3; // [RULE_11]
				`OPC_TRLD1: dif.op = OP_TRLD1; // [RULE_12]
				`OPC_TRLD3: dif.op = OP_TRLD3; // [RULE_13]
				default: dif.op = OP_NONE;
			endcase
		end
	end

endmodule

/* acc_to_reg_transfer_decode.sv */
`timescale 1ns/10ps
`include "acc_xfer_regs.svh"

// How it works
// [RULE_01] Each instruction is one word, one cycle, keeps carry, never skips.
// [RULE_02] Opcode 1000101011 copies the working register to output structure control 3.
// [RULE_03] Two opcodes load interrupt control one and two; two is 1000011000.
// [RULE_04] Opcode 1000000010 copies the working register to serial control.
// [RULE_05] Three opcodes load wakeup registers; 1000011011 for 0, 1000010101 for 2.
// [RULE_06] Store writes working register to RAM, then XORs column pointer with j.
// [RULE_07] One instruction copies the whole working register to clock control.
// [RULE_08] One instruction copies only working register bit 0 to timer auxiliary control.
// [RULE_09] Opcode 1000110101 loads prescaler counter and reload from operand and working register.
// [RULE_10] Opcodes 1000101101 and 1000101110 load pull-up registers 0 and 1.
// [RULE_11] Three opcodes load A/D control; 1000000100 first, 1000000101 second.
// [RULE_12] Opcode 1000111111 loads first timer reload, operand high, working low.
// [RULE_13] Opcode 1000111011 loads third timer reload in one cycle.
// [RULE_14] Third timer reload takes operand as high nibble, working register as low.
// [RULE_15] Only the fully matching target is written; everything else holds.
module acc_to_reg_transfer_decode
#(
	parameter int RAM_DEPTH = 256
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic instr_done,
	output logic carry_flag,
	output logic skip_next,
	output logic [3:0] output_structure_ctrl3,
	output logic [3:0] irq_control_one,
	output logic [3:0] irq_control_two,
	output logic [3:0] sio_control,
	output logic [3:0] wakeup_enable_port0,
	output logic [3:0] wakeup_enable_port1,
	output logic [3:0] wakeup_enable_port2,
	output logic [3:0] clock_control_reg,
	output logic timer_aux_control,
	output logic [7:0] prescaler_reload,
	output logic [7:0] prescaler_counter,
	output logic [3:0] pullup_enable_0,
	output logic [3:0] pullup_enable_1,
	output logic [3:0] adc_control_first,
	output logic [3:0] adc_control_second,
	output logic [3:0] adc_control_third,
	output logic [7:0] first_timer_reload,
	output logic [7:0] third_timer_reload
);
	import acc_xfer_pkg::*;

	// ==========================================================
	// Helpers.
	// Joins the operand register (high) and the working register (low) into a byte.
	function automatic logic [7:0] join_nibbles(input logic [3:0] hi, input logic [3:0] lo);
		join_nibbles = {hi, lo};
	endfunction

	// Places a nibble in the low bits of a bus word.
	function automatic logic [31:0] nib_word(input logic [3:0] n);
		nib_word = {28'h0000000, n};
	endfunction

	// Places a byte in the low bits of a bus word.
	function automatic logic [31:0] byte_word(input logic [7:0] b);
		byte_word = {24'h000000, b};
	endfunction

	// ==========================================================
	// State.
	logic [3:0] acc_r, acc_nxt, opb_r, opb_nxt, col_r, col_nxt, row_r, row_nxt;
	logic [3:0] fr3_r, fr3_nxt, irq1_r, irq1_nxt, irq2_r, irq2_nxt, sio_r, sio_nxt;
	logic [3:0] wake0_r, wake0_nxt, wake1_r, wake1_nxt, wake2_r, wake2_nxt, clk_r, clk_nxt;
	logic [3:0] pu0_r, pu0_nxt, pu1_r, pu1_nxt, adc1_r, adc1_nxt, adc2_r, adc2_nxt, adc3_r, adc3_nxt;
	logic [7:0] psrld_r, psrld_nxt, pscnt_r, pscnt_nxt, trld1_r, trld1_nxt, trld3_r, trld3_nxt;
	logic carry_r, carry_nxt, taux_r, taux_nxt, done_r, done_nxt;
	logic pready_r, pready_nxt, pslverr_r, pslverr_nxt;
	logic [9:0] last_opc_r, last_opc_nxt;
	logic [31:0] prdata_r, prdata_nxt;
	logic [3:0] ram [RAM_DEPTH];
	logic ram_we;
	logic [7:0] ram_addr;
	logic [31:0] rd_word;
	logic rd_hit;
	logic wr_fire;
	logic exec;

	// ==========================================================
	// Decoder.
	decode_if dif ();
	opcode_decode opcode_decode_inst
	(
		.dif(dif.dec)
	);

	assign dif.opcode = pwdata[9:0];

	// ==========================================================
	// Bus handshake: one wait cycle so read data leaves a flip-flop.
	assign wr_fire = psel && penable && pready_r && pwrite;
	assign exec = wr_fire && (paddr == `ADDR_INSTR);
	assign ram_addr = {col_r, row_r};

	// Read multiplexer, also flags unmapped addresses.
	always_comb
	begin
		rd_hit = 1'b1;
		rd_word = 32'h00000000;
		if (paddr == `ADDR_INSTR)
			rd_word = {22'h0, last_opc_r};
		else if (paddr == `ADDR_ACC)
			rd_word = nib_word(acc_r);
		else if (paddr == `ADDR_OPB)
			rd_word = nib_word(opb_r);
		else if (paddr == `ADDR_COL)
			rd_word = nib_word(col_r);
		else if (paddr == `ADDR_ROW)
			rd_word = nib_word(row_r);
		else if (paddr == `ADDR_CARRY)
			rd_word = {31'h0, carry_r};
		else if (paddr == `ADDR_MEMDATA)
			rd_word = nib_word(ram[ram_addr]);
		else if (paddr == `ADDR_FR3)
			rd_word = nib_word(fr3_r);
		else if (paddr == `ADDR_IRQ1)
			rd_word = nib_word(irq1_r);
		else if (paddr == `ADDR_IRQ2)
			rd_word = nib_word(irq2_r);
		else if (paddr == `ADDR_SIO)
			rd_word = nib_word(sio_r);
		else if (paddr == `ADDR_WAKE0)
			rd_word = nib_word(wake0_r);
		else if (paddr == `ADDR_WAKE1)
			rd_word = nib_word(wake1_r);
		else if (paddr == `ADDR_WAKE2)
			rd_word = nib_word(wake2_r);
		else if (paddr == `ADDR_CLK)
			rd_word = nib_word(clk_r);
		else if (paddr == `ADDR_TAUX)
			rd_word = {31'h0, taux_r};
		else if (paddr == `ADDR_PSRLD)
			rd_word = byte_word(psrld_r);
		else if (paddr == `ADDR_PSCNT)
			rd_word = byte_word(pscnt_r);
		else if (paddr == `ADDR_PU0)
			rd_word = nib_word(pu0_r);
		else if (paddr == `ADDR_PU1)
			rd_word = nib_word(pu1_r);
		else if (paddr == `ADDR_ADC1)
			rd_word = nib_word(adc1_r);
		else if (paddr == `ADDR_ADC2)
			rd_word = nib_word(adc2_r);
		else if (paddr == `ADDR_ADC3)
			rd_word = nib_word(adc3_r);
		else if (paddr == `ADDR_TRLD1)
			rd_word = byte_word(trld1_r);
		else if (paddr == `ADDR_TRLD3)
			rd_word = byte_word(trld3_r);
		else
			rd_hit = 1'b0;
	end

	// Next values of the bus answer.
	always_comb
	begin
		pready_nxt = psel && penable && !pready_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = 1'b0;
		if (psel && penable && !pready_r)
		begin
			prdata_nxt = pwrite ? 32'h00000000 : rd_word;
			pslverr_nxt = !rd_hit;
		end
	end

	// ==========================================================
	// Instruction execution: one write to the instruction word is one cycle.
	always_comb
	begin
		acc_nxt = acc_r;
		opb_nxt = opb_r;
		col_nxt = col_r;
		row_nxt = row_r;
		carry_nxt = carry_r; // [RULE_01]
		last_opc_nxt = last_opc_r;
		done_nxt = exec; // [RULE_01]
		fr3_nxt = fr3_r;
		irq1_nxt = irq1_r;
		irq2_nxt = irq2_r;
		sio_nxt = sio_r;
		wake0_nxt = wake0_r;
		wake1_nxt = wake1_r;
		wake2_nxt = wake2_r;
		clk_nxt = clk_r;
		taux_nxt = taux_r;
		psrld_nxt = psrld_r;
		pscnt_nxt = pscnt_r;
		pu0_nxt = pu0_r;
		pu1_nxt = pu1_r;
		adc1_nxt = adc1_r;
		adc2_nxt = adc2_r;
		adc3_nxt = adc3_r;
		trld1_nxt = trld1_r;
		trld3_nxt = trld3_r;
		ram_we = 1'b0;
		// Software loads of the core registers.
		if (wr_fire)
		begin
			if (paddr == `ADDR_ACC)
				acc_nxt = pwdata[3:0];
			else if (paddr == `ADDR_OPB)
				opb_nxt = pwdata[3:0];
			else if (paddr == `ADDR_COL)
				col_nxt = pwdata[3:0];
			else if (paddr == `ADDR_ROW)
				row_nxt = pwdata[3:0];
			else if (paddr == `ADDR_CARRY)
				carry_nxt = pwdata[0];
		end
		// The decoded target alone is written; the rest hold.
		if (exec)
		begin
			last_opc_nxt = pwdata[9:0];
			case (dif.op) // [RULE_15]
				OP_FR3: fr3_nxt = acc_r; // [RULE_02]
				OP_IRQ1: irq1_nxt = acc_r; // [RULE_03]
				OP_IRQ2: irq2_nxt = acc_r; // [RULE_03]
				OP_SIO: sio_nxt = acc_r; // [RULE_04]
				OP_WAKE0: wake0_nxt = acc_r; // [RULE_05]
				OP_WAKE1: wake1_nxt = acc_r; // [RULE_05]
				OP_WAKE2: wake2_nxt = acc_r; // [RULE_05]
				OP_STORE:
				begin
					ram_we = 1'b1; // [RULE_06]
					col_nxt = col_r ^ dif.imm; // [RULE_06]
				end
				OP_CLK: clk_nxt = acc_r; // [RULE_07]
				OP_TAUX: taux_nxt = acc_r[0]; // [RULE_08]
				OP_PS:
				begin
					psrld_nxt = join_nibbles(opb_r, acc_r); // [RULE_09]
					pscnt_nxt = join_nibbles(opb_r, acc_r); // [RULE_09]
				end
				OP_PU0: pu0_nxt = acc_r; // [RULE_10]
				OP_PU1: pu1_nxt = acc_r; // [RULE_10]
				OP_ADC1: adc1_nxt = acc_r; // [RULE_11]
				OP_ADC2: adc2_nxt = acc_r; // [RULE_11]
				OP_ADC3: adc3_nxt = acc_r; // [RULE_11]
				OP_TRLD1: trld1_nxt = join_nibbles(opb_r, acc_r); // [RULE_12]
				OP_TRLD3: trld3_nxt = join_nibbles(opb_r, acc_r); // [RULE_13] [RULE_14]
				default: done_nxt = exec;
			endcase
		end
	end

	// ==========================================================
	// RAM: written by the store instruction at the pointed word, old column used.
	always_ff @(posedge pclk)
	begin
		if (ram_we)
			ram[ram_addr] <= acc_r; // [RULE_06]
	end

	// Registers of the block.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_r <= `RST_NIB;
			opb_r <= `RST_NIB;
			col_r <= `RST_NIB;
			row_r <= `RST_NIB;
			carry_r <= 1'b0;
			last_opc_r <= `RST_OPC;
			done_r <= 1'b0;
			fr3_r <= `RST_NIB;
			irq1_r <= `RST_NIB;
			irq2_r <= `RST_NIB;
			sio_r <= `RST_NIB;
			wake0_r <= `RST_NIB;
			wake1_r <= `RST_NIB;
			wake2_r <= `RST_NIB;
			clk_r <= `RST_NIB;
			taux_r <= 1'b0;
			psrld_r <= `RST_BYTE;
			pscnt_r <= `RST_BYTE;
			pu0_r <= `RST_NIB;
			pu1_r <= `RST_NIB;
			adc1_r <= `RST_NIB;
			adc2_r <= `RST_NIB;
			adc3_r <= `RST_NIB;
			trld1_r <= `RST_BYTE;
			trld3_r <= `RST_BYTE;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h00000000;
		end
		else
		begin
			acc_r <= acc_nxt;
			opb_r <= opb_nxt;
			col_r <= col_nxt;
			row_r <= row_nxt;
			carry_r <= carry_nxt;
			last_opc_r <= last_opc_nxt;
			done_r <= done_nxt;
			fr3_r <= fr3_nxt;
			irq1_r <= irq1_nxt;
			irq2_r <= irq2_nxt;
			sio_r <= sio_nxt;
			wake0_r <= wake0_nxt;
			wake1_r <= wake1_nxt;
			wake2_r <= wake2_nxt;
			clk_r <= clk_nxt;
			taux_r <= taux_nxt;
			psrld_r <= psrld_nxt;
			pscnt_r <= pscnt_nxt;
			pu0_r <= pu0_nxt;
			pu1_r <= pu1_nxt;
			adc1_r <= adc1_nxt;
			adc2_r <= adc2_nxt;
			adc3_r <= adc3_nxt;
			trld1_r <= trld1_nxt;
			trld3_r <= trld3_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r <= prdata_nxt;
		end
	end

	// ==========================================================
	// Outputs straight from flip-flops except skip_next, which is tied low; nothing here requests a skip.
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign instr_done = done_r;
	assign carry_flag = carry_r;
	assign skip_next = 1'b0; // [RULE_01]
	assign output_structure_ctrl3 = fr3_r;
	assign irq_control_one = irq1_r;
	assign irq_control_two = irq2_r;
	assign sio_control = sio_r;
	assign wakeup_enable_port0 = wake0_r;
	assign wakeup_enable_port1 = wake1_r;
	assign wakeup_enable_port2 = wake2_r;
	assign clock_control_reg = clk_r;
	assign timer_aux_control = taux_r;
	assign prescaler_reload = psrld_r;
	assign prescaler_counter = pscnt_r;
	assign pullup_enable_0 = pu0_r;
	assign pullup_enable_1 = pu1_r;
	assign adc_control_first = adc1_r;
	assign adc_control_second = adc2_r;
	assign adc_control_third = adc3_r;
	assign first_timer_reload = trld1_r;
	assign third_timer_reload = trld3_r;

endmodule

/* acc_xfer_properties.sv */
`timescale 1ns/10ps
`include "acc_xfer_regs.svh"

// ==========================================================
// Checker
module acc_xfer_properties
#(
	parameter int RAM_DEPTH = 256
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	input wire logic instr_done,
	input wire logic carry_flag,
	input wire logic skip_next,
	input wire logic [3:0] output_structure_ctrl3,
	input wire logic [3:0] wakeup_enable_port0,
	input wire logic timer_aux_control,
	input wire logic [7:0] prescaler_reload,
	input wire logic [7:0] prescaler_counter,
	input wire logic [7:0] first_timer_reload,
	input wire logic [7:0] third_timer_reload
);
	logic [3:0] acc_r;
	logic [3:0] acc_nxt;
	logic [3:0] opb_r;
	logic [3:0] opb_nxt;
	logic wr_w;
	logic ins_w;
	logic carry_wr_w;
	logic wake0_w;
	logic [7:0] pair_w;

	// A write completes when the access phase sees ready.
	assign wr_w = psel && penable && pready && pwrite;
	assign ins_w = wr_w && paddr == `ADDR_INSTR;
	// Plain signals for the sampled-value functions to look back on.
	assign carry_wr_w = wr_w && paddr == `ADDR_CARRY;
	assign wake0_w = ins_w && pwdata[9:0] == `OPC_WAKE0;
	assign pair_w = {opb_r, acc_r};

	// Shadow copies of the working and second operand registers.
	always_comb
	begin
		acc_nxt = acc_r;
		opb_nxt = opb_r;
		if (wr_w && paddr == `ADDR_ACC)
			acc_nxt = pwdata[3:0];
		if (wr_w && paddr == `ADDR_OPB)
			opb_nxt = pwdata[3:0];
	end

	// Registers the shadows.
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			acc_r <= 4'h0;
			opb_r <= 4'h0;
		end
		else
		begin
			acc_r <= acc_nxt;
			opb_r <= opb_nxt;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_one_wait: assert property (psel && !penable |=> !pready ##1 pready) else $error("ready timing wrong");
	a_skip_never: assert property (!skip_next) else $error("skip raised");
	a_carry_held: assert property ($changed(carry_flag) |-> $past(carry_wr_w))
		else $error("carry changed by instruction");
	a_done_next: assert property (ins_w |=> instr_done ##1 !instr_done) else $error("done pulse wrong");
	a_fr3_load: assert property (ins_w && pwdata[9:0] == 10'h22b |=> output_structure_ctrl3 == $past(acc_r))
		else $error("structure control load wrong");
	a_taux_bit: assert property (ins_w && pwdata[9:0] == 10'h2aa |=> {3'h0, timer_aux_control} == ($past(acc_r) & 4'h1))
		else $error("timer aux load wrong");
	a_ps_pair: assert property (ins_w && pwdata[9:0] == 10'h235 |=>
		prescaler_reload == $past(pair_w) && prescaler_counter == prescaler_reload) else $error("prescaler load wrong");
	a_trld1_byte: assert property (ins_w && pwdata[9:0] == 10'h23f |=>
		first_timer_reload == $past(pair_w)) else $error("first reload wrong");
	a_trld3_byte: assert property (ins_w && pwdata[9:0] == 10'h23b |=>
		third_timer_reload == $past(pair_w)) else $error("third reload wrong");
	a_wake_hold: assert property ($changed(wakeup_enable_port0) |-> $past(wake0_w))
		else $error("wakeup changed without its opcode");
endmodule

bind acc_to_reg_transfer_decode acc_xfer_properties #(.RAM_DEPTH(RAM_DEPTH)) acc_xfer_properties_inst (.pclk, .presetn,
	.psel, .penable, .pwrite, .paddr, .pwdata, .pready, .instr_done, .carry_flag, .skip_next, .output_structure_ctrl3,
	.wakeup_enable_port0, .timer_aux_control, .prescaler_reload, .prescaler_counter, .first_timer_reload,
	.third_timer_reload);

/* acc_to_reg_transfer_decode_bench.sv */
`timescale 1ns/10ps
`include "acc_xfer_regs.svh"

// ==========================================================
// Bench
module acc_to_reg_transfer_decode_bench;
	typedef struct packed {logic [31:0] d; logic e;} note_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, instr_done, carry_flag, skip_next, timer_aux_control;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] output_structure_ctrl3, irq_control_one, irq_control_two, sio_control, wakeup_enable_port0;
	logic [3:0] wakeup_enable_port1, wakeup_enable_port2, clock_control_reg, pullup_enable_0, pullup_enable_1;
	logic [3:0] adc_control_first, adc_control_second, adc_control_third;
	logic [7:0] prescaler_reload, prescaler_counter, first_timer_reload, third_timer_reload;
	logic [143:0] outs;
	logic [7:0] m [18];
	logic [9:0] opc [18];
	logic [31:0] rng = 32'h0000005e;
	note_t notes [$];
	note_t cur;
	int miscompares = 0;
	int total_checks = 0;

	acc_to_reg_transfer_decode acc_to_reg_transfer_decode_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .instr_done, .carry_flag, .skip_next, .output_structure_ctrl3,
		.irq_control_one, .irq_control_two, .sio_control, .wakeup_enable_port0, .wakeup_enable_port1,
		.wakeup_enable_port2, .clock_control_reg, .timer_aux_control, .prescaler_reload, .prescaler_counter,
		.pullup_enable_0, .pullup_enable_1, .adc_control_first, .adc_control_second, .adc_control_third,
		.first_timer_reload, .third_timer_reload);

	// Target outputs as bytes, index matching the target address order.
	assign outs = {third_timer_reload, first_timer_reload, 4'h0, adc_control_third, 4'h0, adc_control_second,
		4'h0, adc_control_first, 4'h0, pullup_enable_1, 4'h0, pullup_enable_0, prescaler_counter, prescaler_reload,
		7'h00, timer_aux_control, 4'h0, clock_control_reg, 4'h0, wakeup_enable_port2, 4'h0, wakeup_enable_port1,
		4'h0, wakeup_enable_port0, 4'h0, sio_control, 4'h0, irq_control_two, 4'h0, irq_control_one,
		4'h0, output_structure_ctrl3};

	// Clock of 8 ns.
	always #4 pclk = ~pclk;

	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// One APB transfer; the request holds until ready is seen at an edge.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 40);
		if (n >= 40)
			miscompares++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d, input logic e);
		notes.push_back('{d, e});
		apb(1'b0, a, 32'h0);
	endtask

	// Reads every target back and compares its port too.
	task automatic verify_all();
		for (int k = 0; k < 18; k++)
		begin
			rd(12'h020 + 12'(4 * k), {24'h0, m[k]}, 1'b0);
			check("target port", {24'h0, outs[k * 8 +: 8]}, {24'h0, m[k]});
		end
	endtask

	// Compares each read answer with the oldest note.
	always @(posedge pclk)
		if (psel && penable && pready === 1'b1 && !pwrite)
		begin
			cur = notes.pop_front();
			check("prdata", prdata, cur.d);
			check("pslverr", {31'h0, pslverr}, {31'h0, cur.e});
		end

	// Cuts a hang short.
	initial
	begin
		#200000;
		miscompares++;
		end_sim();
	end

	// Main sequence.
	initial
	begin
		logic [31:0] x;
		logic [3:0] j;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		foreach (m[k])
			m[k] = 8'h00;
		opc = '{10'h22b, 10'h217, 10'h218, 10'h202, 10'h21b, 10'h214, 10'h215, 10'h296, 10'h2aa, 10'h235, 10'h235,
			10'h22d, 10'h22e, 10'h204, 10'h205, 10'h206, 10'h23f, 10'h23b};
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		verify_all();
		$display("reset values done");
		wr(`ADDR_CARRY, 32'h1);
		for (int i = 0; i < 18; i++)
		begin
			if (i == 10)
				continue;
			x = rnd() | 32'h00000011; // Nonzero nibbles, so every load shows on its target.
			wr(`ADDR_ACC, {28'h0, x[3:0]});
			wr(`ADDR_OPB, {28'h0, x[7:4]});
			wr(`ADDR_INSTR, {22'h0, opc[i]});
			case (i)
				8: m[8] = {7'h00, x[0]};
				9:
				begin
					m[9] = x[7:0];
					m[10] = x[7:0];
				end
				16, 17: m[i] = x[7:0];
				default: m[i] = {4'h0, x[3:0]};
			endcase
			verify_all();
			rd(`ADDR_ACC, {28'h0, x[3:0]}, 1'b0);
		end
		$display("transfers done");
		for (int k = 0; k < 2; k++)
		begin
			x = rnd();
			j = k ? 4'hf : x[15:12];
			wr(`ADDR_COL, {28'h0, x[3:0]});
			wr(`ADDR_ROW, {28'h0, x[7:4]});
			wr(`ADDR_ACC, {28'h0, x[11:8]});
			wr(`ADDR_INSTR, {22'h0, 6'h2b, j});
			rd(`ADDR_COL, {28'h0, x[3:0] ^ j}, 1'b0);
			wr(`ADDR_COL, {28'h0, x[3:0]});
			rd(`ADDR_MEMDATA, {28'h0, x[11:8]}, 1'b0);
		end
		$display("store done");
		wr(12'h020, 32'hf);
		wr(`ADDR_INSTR, 32'h22c);
		verify_all();
		rd(12'hffc, 32'h0, 1'b1);
		rd(`ADDR_INSTR, 32'h22c, 1'b0);
		check("carry", {31'h0, carry_flag}, 32'h1);
		check("skip", {31'h0, skip_next}, 32'h0);
		rd(`ADDR_CARRY, 32'h1, 1'b0);
		check("notes left", 32'(notes.size()), 32'h0);
		$display("refusals done");
		end_sim();
	end
endmodule
